// ===== bcs_pkg.sv
/*
 bcs_pkg: constants and types of the bus cycle sequencer.
 Assumes it is compiled before bcs_sequencer.sv.
*/
`default_nettype none
package bcs_pkg;
   // ----------------------------------------------------------------
   // operation request codes
   // ----------------------------------------------------------------
   localparam logic [4:0] OP_ALU = 5'h00; // alu, jump, jsr: one fetch
   localparam logic [4:0] OP_SKIP_ALU = 5'h01; // alu with skip: two fetch
   localparam logic [4:0] OP_ISZ_DIR = 5'h02; // inc/dec skip direct
   localparam logic [4:0] OP_ISZ_IND = 5'h03; // inc/dec skip, sta indirect
   localparam logic [4:0] OP_JMP_IND = 5'h04; // jump/jsr indirect, sta
   localparam logic [4:0] OP_LDA = 5'h05; // load accumulator
   localparam logic [4:0] OP_LDA_IND = 5'h06; // load accumulator indirect
   localparam logic [4:0] OP_IO_IN = 5'h07; // data in, skip busy/done
   localparam logic [4:0] OP_IO_OUT = 5'h08; // data out
   localparam logic [4:0] OP_INTR = 5'h09; // interrupt service
   localparam logic [4:0] OP_WAIT = 5'h0A; // wait
   localparam logic [4:0] OP_CON_ACC = 5'h0B; // examine/deposit acc
   localparam logic [4:0] OP_CON_MEM = 5'h0C; // load pc, examine mem/next
   localparam logic [4:0] OP_CON_DEP = 5'h0D; // deposit mem/next
   localparam logic [4:0] OP_CON_CONT = 5'h0E; // console continue

   // ----------------------------------------------------------------
   // cycle kinds, also used in the sequence table
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      BCS_CYC_FETCH = 3'h0,
      BCS_CYC_READ = 3'h1,
      BCS_CYC_WRITE = 3'h2,
      BCS_CYC_LDADDR = 3'h3,
      BCS_CYC_IOOUT = 3'h4,
      BCS_CYC_IOIN = 3'h5,
      BCS_CYC_WAIT = 3'h6,
      BCS_CYC_DCH = 3'h7
   } bcs_cycle_e;

   // ----------------------------------------------------------------
   // cycle codes on memory control (active low) and aux lines
   // ----------------------------------------------------------------
   localparam logic [2:0] MC_IDLE_N = 3'h7; // released / no cycle
   localparam logic [1:0] AUX_IDLE = 2'h0;
   localparam logic [15:0] IB_RESET = 16'h0000;
   // pin idle levels: busy low, channel and interrupt requests high
   localparam logic [6:0] SYNC_IDLE = 7'h30;

   // ----------------------------------------------------------------
   // timing: one bus cycle takes CYCLE_NS unless memory stretches it
   // ----------------------------------------------------------------
   localparam int CLK_NS = 10;
   localparam int CYCLE_NS = 100;
   localparam int CYCLE_CLKS = (CYCLE_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] CYC_LAST = 4'(CYCLE_CLKS - 1);
   localparam int SEQ_MAX = 5; // longest cycle series
endpackage
`default_nettype wire

// ===== bcs_sequencer.sv
/*
 bcs_sequencer: bus cycle sequencer of a 16-bit processor core.
 Assumes a core that posts one operation at a time with op_valid,
 supplies next bus data, and owns run/carry/interrupt-on state.
*/
`default_nettype none
module bcs_sequencer (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [4:0] op_code, // operation to sequence
   input wire logic op_valid, // core offers an operation
   output logic op_ready, // operation taken this cycle
   output logic seq_done, // last cycle of a series ends
   input wire logic [15:0] bus_next_data, // prepared by the core
   input wire logic run_in, // core status to present
   input wire logic carry_in,
   input wire logic int_on_in,
   input wire logic memory_busy_n, // pin: busy, low = go on
   input wire logic data_channel_request_n, // pin
   input wire logic interrupt_request_n, // pin
   input wire logic [3:0] console_control_inputs, // pin
   output logic [3:0] console_sync, // synchronised console lines
   output logic int_pending, // synchronised interrupt request
   output logic [15:0] information_bus_o,
   output logic information_bus_oe_n, // low while driving
   input wire logic [15:0] information_bus_i,
   output logic [15:0] bus_captured, // bus word at cycle end
   output logic [2:0] memory_control_n_o,
   output logic memory_control_n_oe_n, // low while driving
   output logic [1:0] aux_cycle_outputs,
   output logic cycle_sync_n, // low one clock at cycle start
   output logic data_channel_cycle, // high during channel cycle
   output logic load_address_cycle, // high during load address
   output logic run_out,
   output logic carry_out,
   output logic int_on_out
);
   // ----------------------------------------------------------------
   // cycle code table
   // ----------------------------------------------------------------
   // memory control code for a cycle kind
   function automatic logic [2:0] mc_code(bcs_pkg::bcs_cycle_e c);
      mc_code = ~3'(c);
   endfunction

   // aux line code for a cycle kind
   function automatic logic [1:0] aux_code(bcs_pkg::bcs_cycle_e c);
      aux_code = 2'(c);
   endfunction

   // length and nth cycle of each operation series
   function automatic logic [2:0] seq_len(logic [4:0] op);
      case (op)
         bcs_pkg::OP_SKIP_ALU, bcs_pkg::OP_LDA, bcs_pkg::OP_IO_IN,
         bcs_pkg::OP_IO_OUT, bcs_pkg::OP_CON_CONT: seq_len = 3'h2;
         bcs_pkg::OP_ISZ_DIR, bcs_pkg::OP_JMP_IND, bcs_pkg::OP_CON_ACC,
         bcs_pkg::OP_CON_MEM: seq_len = 3'h3;
         bcs_pkg::OP_LDA_IND, bcs_pkg::OP_CON_DEP: seq_len = 3'h4;
         bcs_pkg::OP_ISZ_IND, bcs_pkg::OP_INTR: seq_len = 3'h5;
         default: seq_len = 3'h1;
      endcase
   endfunction

   function automatic bcs_pkg::bcs_cycle_e seq_cyc(logic [4:0] op,
         logic [2:0] n);
      bcs_pkg::bcs_cycle_e r;
      r = bcs_pkg::BCS_CYC_FETCH;
      case (op)
         bcs_pkg::OP_ISZ_DIR, bcs_pkg::OP_JMP_IND:
            if (n == 3'h0) r = bcs_pkg::BCS_CYC_READ;
            else if (n == 3'h1) r = bcs_pkg::BCS_CYC_WRITE;
         bcs_pkg::OP_ISZ_IND:
            if (n == 3'h0 || n == 3'h2) r = bcs_pkg::BCS_CYC_READ;
            else if (n != 3'h4) r = bcs_pkg::BCS_CYC_WRITE;
         bcs_pkg::OP_LDA:
            if (n == 3'h0) r = bcs_pkg::BCS_CYC_READ;
         bcs_pkg::OP_LDA_IND:
            if (n == 3'h0 || n == 3'h2) r = bcs_pkg::BCS_CYC_READ;
            else if (n == 3'h1) r = bcs_pkg::BCS_CYC_WRITE;
         bcs_pkg::OP_IO_IN, bcs_pkg::OP_CON_CONT:
            if (n == 3'h0) r = bcs_pkg::BCS_CYC_IOIN;
         bcs_pkg::OP_IO_OUT:
            if (n == 3'h0) r = bcs_pkg::BCS_CYC_IOOUT;
         bcs_pkg::OP_INTR:
            case (n)
               3'h0: r = bcs_pkg::BCS_CYC_LDADDR;
               3'h1, 3'h3: r = bcs_pkg::BCS_CYC_WRITE;
               3'h2: r = bcs_pkg::BCS_CYC_READ;
               default: r = bcs_pkg::BCS_CYC_FETCH;
            endcase
         bcs_pkg::OP_WAIT: r = bcs_pkg::BCS_CYC_WAIT;
         bcs_pkg::OP_CON_ACC:
            case (n)
               3'h0: r = bcs_pkg::BCS_CYC_IOIN;
               3'h1: r = bcs_pkg::BCS_CYC_IOOUT;
               default: r = bcs_pkg::BCS_CYC_WAIT;
            endcase
         bcs_pkg::OP_CON_MEM:
            case (n)
               3'h0: r = bcs_pkg::BCS_CYC_IOIN;
               3'h1: r = bcs_pkg::BCS_CYC_READ;
               default: r = bcs_pkg::BCS_CYC_WAIT;
            endcase
         bcs_pkg::OP_CON_DEP:
            case (n)
               3'h0: r = bcs_pkg::BCS_CYC_IOIN;
               3'h1: r = bcs_pkg::BCS_CYC_LDADDR;
               3'h2: r = bcs_pkg::BCS_CYC_WRITE;
               default: r = bcs_pkg::BCS_CYC_WAIT;
            endcase
         default: r = bcs_pkg::BCS_CYC_FETCH; // alu/jump
      endcase
      seq_cyc = r;
   endfunction

   // ----------------------------------------------------------------
   // pin synchronisers: three stages, change taken when 2 and 3 agree
   // ----------------------------------------------------------------
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] pin_raw; // busy, dch, int, console[3:0]
   logic [NSYNC-1:0] s1_q, s2_q, s3_q, s1_d, s2_d, s3_d;
   logic [NSYNC-1:0] filt_q, filt_d; // accepted levels
   assign pin_raw = {memory_busy_n, data_channel_request_n,
                     interrupt_request_n, console_control_inputs};

   // next values of the sync chain; idle levels after reset
   always_comb begin
      s1_d = pin_raw;
      s2_d = s1_q;
      s3_d = s2_q;
      filt_d = filt_q;
      for (int i = 0; i < NSYNC; i++) begin
         if (s2_q[i] == s3_q[i]) filt_d[i] = s3_q[i];
      end
      if (rst) begin
         s1_d = bcs_pkg::SYNC_IDLE;
         s2_d = bcs_pkg::SYNC_IDLE;
         s3_d = bcs_pkg::SYNC_IDLE;
         filt_d = bcs_pkg::SYNC_IDLE;
      end
   end

   // sync chain registers
   always_ff @(posedge clk_sys) begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      filt_q <= filt_d;
   end

   logic busy_n, data_channel_request_n_n;
   assign busy_n = filt_q[6];
   assign data_channel_request_n_n = filt_q[5];
   assign int_pending = ~filt_q[4];
   assign console_sync = filt_q[3:0];

   // ----------------------------------------------------------------
   // sequencer state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      BCS_ST_IDLE = 2'h0,
      BCS_ST_RUN = 2'h1, // bus cycle timing
      BCS_ST_STALL = 2'h3 // waiting on memory busy
   } bcs_state_e;

   bcs_state_e st_q, st_d;
   logic [4:0] op_q, op_d;
   logic [2:0] idx_q, idx_d, len_q, len_d;
   logic [3:0] tick_q, tick_d; // clocks into the current cycle
   bcs_pkg::bcs_cycle_e cyc_q, cyc_d;
   logic [15:0] ib_q, ib_d, cap_q, cap_d;
   logic run_q, run_d, carry_q, carry_d, inton_q, inton_d;
   logic sync_q, sync_d, ready_c, done_c, cyc_end, frozen, mem_cyc;

   // read/write cycles freeze the status outputs
   assign frozen = (cyc_q == bcs_pkg::BCS_CYC_READ) ||
                   (cyc_q == bcs_pkg::BCS_CYC_WRITE);
   // memory cycles that wait on busy
   assign mem_cyc = (cyc_q == bcs_pkg::BCS_CYC_FETCH) ||
                    (cyc_q == bcs_pkg::BCS_CYC_READ) ||
                    (cyc_q == bcs_pkg::BCS_CYC_WRITE);
   assign cyc_end = (tick_q == bcs_pkg::CYC_LAST);

   // next-state logic of the sequencer
   always_comb begin
      st_d = st_q;
      op_d = op_q;
      idx_d = idx_q;
      len_d = len_q;
      tick_d = tick_q;
      cyc_d = cyc_q;
      ib_d = ib_q;
      cap_d = cap_q;
      sync_d = 1'b1;
      ready_c = 1'b0;
      done_c = 1'b0;
      // status follows the core except while frozen
      run_d = frozen && st_q != BCS_ST_IDLE ? run_q : run_in;
      carry_d = frozen && st_q != BCS_ST_IDLE ? carry_q : carry_in;
      inton_d = frozen && st_q != BCS_ST_IDLE ? inton_q : int_on_in;
      case (st_q)
         BCS_ST_IDLE: begin
            // channel request wins over an offer, sampled only between series
            if (!data_channel_request_n_n) begin
               op_d = bcs_pkg::OP_ALU;
               len_d = 3'h1;
               idx_d = 3'h0;
               cyc_d = bcs_pkg::BCS_CYC_DCH;
               tick_d = 4'h0;
               sync_d = 1'b0;
               st_d = BCS_ST_RUN;
            end else if (op_valid) begin
               ready_c = 1'b1;
               op_d = op_code;
               len_d = seq_len(op_code);
               idx_d = 3'h0;
               cyc_d = seq_cyc(op_code, 3'h0);
               tick_d = 4'h0;
               sync_d = 1'b0;
               ib_d = bus_next_data;
               st_d = BCS_ST_RUN;
            end
         end
         BCS_ST_RUN, BCS_ST_STALL: begin
            if (!cyc_end) begin
               tick_d = tick_q + 4'h1;
            end else if (mem_cyc && busy_n) begin
               st_d = BCS_ST_STALL;
            end else if (idx_q + 3'h1 >= len_q) begin
               cap_d = information_bus_i;
               done_c = 1'b1;
               cyc_d = bcs_pkg::BCS_CYC_WAIT;
               st_d = BCS_ST_IDLE;
            end else begin
               cap_d = information_bus_i;
               idx_d = idx_q + 3'h1;
               cyc_d = seq_cyc(op_q, idx_q + 3'h1);
               tick_d = 4'h0;
               sync_d = 1'b0;
               ib_d = bus_next_data;
               st_d = BCS_ST_RUN;
            end
         end
         default: st_d = BCS_ST_IDLE;
      endcase
      if (rst) begin
         st_d = BCS_ST_IDLE;
         op_d = bcs_pkg::OP_ALU;
         idx_d = 3'h0;
         len_d = 3'h1;
         tick_d = 4'h0;
         cyc_d = bcs_pkg::BCS_CYC_WAIT;
         ib_d = bcs_pkg::IB_RESET;
         cap_d = bcs_pkg::IB_RESET;
         run_d = 1'b0;
         carry_d = 1'b0;
         inton_d = 1'b0;
         sync_d = 1'b1;
      end
   end

   // sequencer registers
   always_ff @(posedge clk_sys) begin
      st_q <= st_d;
      op_q <= op_d;
      idx_q <= idx_d;
      len_q <= len_d;
      tick_q <= tick_d;
      cyc_q <= cyc_d;
      ib_q <= ib_d;
      cap_q <= cap_d;
      run_q <= run_d;
      carry_q <= carry_d;
      inton_q <= inton_d;
      sync_q <= sync_d;
   end

   // ----------------------------------------------------------------
   // pin drive
   // ----------------------------------------------------------------
   logic active, is_dch, drive_ib;
   assign active = (st_q != BCS_ST_IDLE);
   assign is_dch = active && (cyc_q == bcs_pkg::BCS_CYC_DCH);
   // bus only driven on cycles that present core data
   assign drive_ib = active && !is_dch &&
                     (cyc_q != bcs_pkg::BCS_CYC_IOIN) &&
                     (cyc_q != bcs_pkg::BCS_CYC_READ);
   assign information_bus_o = ib_q;
   assign information_bus_oe_n = ~drive_ib;
   assign memory_control_n_o = active ? mc_code(cyc_q)
                                      : bcs_pkg::MC_IDLE_N;
   assign memory_control_n_oe_n = is_dch || !active;
   assign aux_cycle_outputs = active ? aux_code(cyc_q)
                                     : bcs_pkg::AUX_IDLE;
   assign data_channel_cycle = is_dch;
   assign load_address_cycle =
      active && (cyc_q == bcs_pkg::BCS_CYC_LDADDR);
   assign cycle_sync_n = sync_q;
   assign bus_captured = cap_q;
   assign run_out = run_q;
   assign carry_out = carry_q;
   assign int_on_out = inton_q;
   assign op_ready = ready_c;
   assign seq_done = done_c;
endmodule
`default_nettype wire

// ===== bcs_properties.sv
/*
 bcs_properties: concurrent checks on the sequencer ports.
 Assumes one clock clk_sys and a synchronous active-high rst.
*/
`default_nettype none
module bcs_properties (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic op_valid,
   input wire logic op_ready,
   input wire logic seq_done,
   input wire logic memory_busy_n,
   input wire logic [2:0] memory_control_n_o,
   input wire logic memory_control_n_oe_n,
   input wire logic [1:0] aux_cycle_outputs,
   input wire logic cycle_sync_n,
   input wire logic data_channel_cycle,
   input wire logic load_address_cycle,
   input wire logic information_bus_oe_n,
   input wire logic run_out,
   input wire logic carry_out,
   input wire logic int_on_out
);
   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic mem_rw; // read or write code on driven lines
   assign mem_rw = !memory_control_n_oe_n &&
      (memory_control_n_o == 3'h6 || memory_control_n_o == 3'h5);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_dch_bus_float: assert property (
      data_channel_cycle |-> information_bus_oe_n)
      else $error("bus driven in channel cycle");
   a_dch_mc_release: assert property (
      data_channel_cycle |-> memory_control_n_oe_n)
      else $error("control lines driven in channel cycle");
   a_dch_no_take: assert property (
      data_channel_cycle |-> !op_ready)
      else $error("operation taken in channel cycle");
   // two clocks in, so the edge that opens the cycle is left out
   a_status_frozen: assert property (
      mem_rw && $past(mem_rw) && cycle_sync_n && $past(cycle_sync_n)
      |-> $stable(run_out) && $stable(carry_out) && $stable(int_on_out))
      else $error("status moved in memory cycle");
   // six high samples outlast the input filter of three to four
   a_busy_stall: assert property (
      (memory_busy_n [*6] ##0 mem_rw) |-> !seq_done ##1 cycle_sync_n)
      else $error("memory cycle ended while busy");
   a_cycle_len: assert property (
      !cycle_sync_n |=> cycle_sync_n [*8])
      else $error("bus cycle too short");
   a_code_steady: assert property (
      !cycle_sync_n |=> $stable(memory_control_n_o) [*8])
      else $error("cycle code changed in cycle");
   a_aux_code: assert property (
      !memory_control_n_oe_n |->
      aux_cycle_outputs == ~memory_control_n_o[1:0])
      else $error("aux code disagrees");
   a_ldaddr_flag: assert property (
      load_address_cycle |->
      !memory_control_n_oe_n && memory_control_n_o == 3'h4)
      else $error("load address flag without its code");
   a_take_start: assert property (
      op_ready |-> op_valid ##1 !cycle_sync_n)
      else $error("take not followed by cycle start");
   c_dch: cover property ($rose(data_channel_cycle));
   c_ldaddr: cover property ($rose(load_address_cycle));
   c_stall: cover property (memory_busy_n [*6] ##0 mem_rw);
   c_done: cover property (seq_done);
endmodule
bind bcs_sequencer bcs_properties u_props (.clk_sys, .rst, .op_valid,
   .op_ready, .seq_done, .memory_busy_n, .memory_control_n_o,
   .memory_control_n_oe_n, .aux_cycle_outputs, .cycle_sync_n,
   .data_channel_cycle, .load_address_cycle, .information_bus_oe_n,
   .run_out, .carry_out, .int_on_out);
`default_nettype wire

// ===== bcs_mem_model.sv
/*
 bcs_mem_model: memory side, stretches memory cycles with busy.
 Assumes the sequencer's cycle codes and one clock clk_sys.
*/
`default_nettype none
module bcs_mem_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic stall_en, // lengthen fetch, read and write
   input wire logic cycle_sync_n,
   input wire logic [2:0] memory_control_n_o,
   input wire logic memory_control_n_oe_n,
   input wire logic [15:0] information_bus_o,
   input wire logic information_bus_oe_n,
   output logic memory_busy_n,
   output logic [15:0] information_bus_i
);
   logic [4:0] hold_q; // clocks of busy still to give
   logic [15:0] pat_q; // moves every clock, so a float is never stale
   // busy rises after cycle start and outlasts the ten-clock cycle
   always_ff @(posedge clk_sys) begin
      pat_q <= rst ? 16'hACE1 : {pat_q[14:0], pat_q[15] ^ pat_q[13]};
      if (rst) begin
         hold_q <= 5'h00;
      end else if (!cycle_sync_n && stall_en && !memory_control_n_oe_n &&
                   memory_control_n_o >= 3'h5) begin
         hold_q <= 5'h0A + {2'h0, pat_q[2:0]};
      end else if (hold_q != 5'h00) begin
         hold_q <= hold_q - 5'h01;
      end
   end
   // busy is high while clocks remain to hold, low when memory is ready
   assign memory_busy_n = (hold_q != 5'h00);
   // wire level: the device's value while it drives, ours otherwise
   assign information_bus_i = information_bus_oe_n ? pat_q :
      information_bus_o;
endmodule
`default_nettype wire

// ===== tb_top.sv
/*
 tb_top: self-checking bench of the bus cycle sequencer.
 Assumes bcs_pkg, bcs_sequencer, bcs_mem_model, bcs_properties.
*/
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0, rst = 1'b1, op_valid = 1'b0, stall_en = 1'b0;
   logic [4:0] op_code = 5'h00;
   logic [15:0] bus_next_data = 16'h0000, information_bus_o;
   logic [15:0] information_bus_i, bus_captured;
   logic run_in = 1'b0, carry_in = 1'b0, int_on_in = 1'b0;
   logic data_channel_request_n = 1'b1, interrupt_request_n = 1'b1;
   logic [3:0] console_control_inputs = 4'h0, console_sync;
   logic op_ready, seq_done, int_pending, information_bus_oe_n;
   logic memory_busy_n, memory_control_n_oe_n, cycle_sync_n;
   logic data_channel_cycle, load_address_cycle;
   logic run_out, carry_out, int_on_out;
   logic [2:0] memory_control_n_o;
   logic [1:0] aux_cycle_outputs;
   logic [2:0] kq[$]; // cycle kinds seen at each cycle start
   logic [15:0] shown = 16'h0000; // data the current cycle presents
   logic shown_ok = 1'b0; // current cycle drives the bus
   int seed = 51090, num_errors = 0, checks = 0, k;
   initial forever #5 clk_sys = ~clk_sys;
   bcs_sequencer dut (.clk_sys, .rst, .op_code, .op_valid, .op_ready,
      .seq_done, .bus_next_data, .run_in, .carry_in, .int_on_in,
      .memory_busy_n, .data_channel_request_n, .interrupt_request_n,
      .console_control_inputs, .console_sync, .int_pending,
      .information_bus_o, .information_bus_oe_n, .information_bus_i,
      .bus_captured, .memory_control_n_o, .memory_control_n_oe_n,
      .aux_cycle_outputs, .cycle_sync_n, .data_channel_cycle,
      .load_address_cycle, .run_out, .carry_out, .int_on_out);
   bcs_mem_model u_mem (.clk_sys, .rst, .stall_en, .cycle_sync_n,
      .memory_control_n_o, .memory_control_n_oe_n, .information_bus_o,
      .information_bus_oe_n, .memory_busy_n, .information_bus_i);
   // ---------------------------------------------------------------
   // recording and random core inputs, both on the falling edge
   // ---------------------------------------------------------------
   always @(negedge clk_sys) begin
      if (!rst && cycle_sync_n === 1'b0) begin
         kq.push_back(data_channel_cycle ? 3'h7 : ~memory_control_n_o);
         // the cycle that just ended captured what it presented
         if (shown_ok)
            chk("bus capture", {8'h0, shown}, {8'h0, bus_captured});
         // bus data was taken at the start edge, one cycle ahead
         shown = bus_next_data;
         shown_ok = (information_bus_oe_n === 1'b0);
         if (shown_ok)
            chk("bus data", {8'h0, shown}, {8'h0, information_bus_o});
      end
      bus_next_data <= 16'($random(seed));
      {run_in, carry_in, int_on_in} <= 3'($random(seed));
   end
   // ---------------------------------------------------------------
   // expectations and shared tasks
   // ---------------------------------------------------------------
   // count nibble, then one nibble per cycle kind, first at the right
   function automatic logic [23:0] exp_seq(input logic [4:0] op);
      case (op)
         bcs_pkg::OP_ALU: exp_seq = 24'h100000;
         bcs_pkg::OP_SKIP_ALU: exp_seq = 24'h200000;
         bcs_pkg::OP_ISZ_DIR, bcs_pkg::OP_JMP_IND: exp_seq = 24'h300021;
         bcs_pkg::OP_ISZ_IND: exp_seq = 24'h502121;
         bcs_pkg::OP_LDA: exp_seq = 24'h200001;
         bcs_pkg::OP_LDA_IND: exp_seq = 24'h400121;
         bcs_pkg::OP_IO_IN, bcs_pkg::OP_CON_CONT: exp_seq = 24'h200005;
         bcs_pkg::OP_IO_OUT: exp_seq = 24'h200004;
         bcs_pkg::OP_INTR: exp_seq = 24'h502123;
         bcs_pkg::OP_WAIT: exp_seq = 24'h100006;
         bcs_pkg::OP_CON_ACC: exp_seq = 24'h300645;
         bcs_pkg::OP_CON_MEM: exp_seq = 24'h300615;
         default: exp_seq = 24'h406235; // console deposit memory
      endcase
   endfunction
   task automatic chk(input string name, input logic [23:0] exp,
                      input logic [23:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic hung();
      num_errors++;
      $display("CHECK FAILED handshake expected done seen timeout");
      give_verdict();
   endtask
   // offer one operation, wait for its series, compare the kinds
   task automatic run_op(input logic [4:0] op);
      int i;
      logic [23:0] obs, want;
      want = exp_seq(op);
      op_code = op;
      op_valid = 1'b1;
      #1;
      for (i = 0; op_ready !== 1'b1; i++) begin
         if (i > 300) hung();
         @(negedge clk_sys);
      end
      kq.delete();
      @(negedge clk_sys);
      op_valid = 1'b0;
      for (i = 0; seq_done !== 1'b1; i++) begin
         if (i > 900) hung();
         @(negedge clk_sys);
      end
      // without stalls each cycle lasts exactly the nominal clock count
      obs = 24'(want[23:20] * bcs_pkg::CYCLE_CLKS - 1);
      if (!stall_en) chk("series clocks", obs, 24'(i));
      @(negedge clk_sys);
      obs = {4'(kq.size()), 20'h00000};
      foreach (kq[j]) if (j < 5) obs[j*4 +: 4] = {1'b0, kq[j]};
      chk("cycle series", want, obs);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (6) @(negedge clk_sys);
      chk("reset lines", 24'h000007, {18'h0, run_out, carry_out,
         int_on_out, cycle_sync_n, information_bus_oe_n,
         memory_control_n_oe_n});
      rst = 1'b0;
      for (k = 0; k < 15; k++) run_op(5'(k));
      $display("test all series done");
      stall_en = 1'b1;
      for (k = 0; k < 30; k++) run_op(5'({$random(seed)} % 15));
      $display("test stalled random series done");
      // channel request pending while an operation is offered; the
      // offer waits for the filtered request so that both meet
      data_channel_request_n = 1'b0;
      repeat (4) @(negedge clk_sys);
      op_code = bcs_pkg::OP_ALU;
      op_valid = 1'b1;
      #1;
      chk("refused take", 24'h000000, {23'h0, op_ready});
      for (k = 0; data_channel_cycle !== 1'b1; k++) begin
         if (k > 300) hung();
         @(negedge clk_sys);
      end
      data_channel_request_n = 1'b1;
      chk("channel lines", 24'h000006, {21'h0, information_bus_oe_n,
         memory_control_n_oe_n, op_ready});
      run_op(bcs_pkg::OP_ALU);
      $display("test channel cycle done");
      for (k = 0; k < 4; k++) begin
         {interrupt_request_n, console_control_inputs} = 5'($random(seed));
         repeat (6) @(negedge clk_sys);
         chk("pin sync", {19'h0, ~interrupt_request_n,
            console_control_inputs}, {19'h0, int_pending, console_sync});
      end
      $display("test pin sync done");
      give_verdict();
   end
endmodule
`default_nettype wire
